/* uad_attach_ctrl.sv */
// What this block does
// R1: Pull D+ only when ready to enumerate
// R2: Pull-up source setting, 16 means internal
// R3: Self-powered: no pull-up without VBUS
// R4: VBUS sense pin chosen by setting
// R5: Bus powered requests 200 mA budget
// R6: Detach and wake pins chosen by settings
// R7: Detach high floats lines, drops pull-up
// R8: Detach low restores pull-up, awaits enumeration
// R9: Wake output high only while detached
// R10: No in-cable remote wake while detached
// R11: Bus-powered suspend stops radio and loads
// R12: Full-speed signalling at 12 Mbit/s
// R13: Peripheral role only, answers host
// R14: Pull-up is ready AND VBUS AND not detached; the code needs VBUS only when self-powered
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "uad_defs.svh"

module uad_attach_ctrl (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    // Avalon-MM slave
    input  wire logic [4:0]             address,
    input  wire logic                   read,
    input  wire logic                   write,
    input  wire logic [31:0]            writedata,
    input  wire logic [3:0]             byteenable,
    output logic      [31:0]            readdata,
    output logic                        waitrequest,
    // General I/O pins
    input  wire logic [`UAD_GIO_W-1:0]  gio_in,
    output logic      [`UAD_GIO_W-1:0]  gio_out,
    output logic      [`UAD_GIO_W-1:0]  gio_oe,
    // USB core side
    input  wire logic                   usb_suspend,
    input  wire logic                   usb_remote_wake_req,
    output logic                        dp_internal_pullup,
    output logic                        usb_lines_hiz,
    output logic                        usb_remote_wake,
    output logic                        usb_full_speed,
    output logic                        usb_peripheral_role,
    output logic      [7:0]             usb_max_power,
    // Power control
    output logic                        radio_enable,
    output logic                        ext_load_enable
);

    logic                   ready_enum;
    logic                   self_powered;
    logic                   wake_req;
    logic [`UAD_SEL_W-1:0]  pullup_pin_select_setting;
    logic [`UAD_SEL_W-1:0]  vbus_pin_select_setting;
    logic [`UAD_SEL_W-1:0]  detach_pin_select_setting;
    logic [`UAD_SEL_W-1:0]  wake_pin_select_setting;
    logic                   reattached;
    logic                   vbus_seen;
    logic                   detach_seen;
    logic                   pullup_on;
    logic                   ext_pullup_on;
    logic                   wake_on;
    logic                   shed_power;
    logic                   in_attached;
    logic                   in_detached;
    logic                   pin_mismatch;
    logic                   wr_take;
    logic                   rd_take;
    logic [31:0]            next_readdata;
    uad_pkg::uad_state_type state;
    uad_pkg::uad_state_type next_state;

    // Decode of the pull-up setting; 16 and above mean the internal source
    function automatic logic is_internal(input logic [`UAD_SEL_W-1:0] sel);
        is_internal = (sel >= `UAD_SEL_INTERNAL);
    endfunction : is_internal

    // Byte-lane merge for the five-bit pin selects, which live in lane 0
    function automatic logic [`UAD_SEL_W-1:0] sel_write(
        input logic [`UAD_SEL_W-1:0] old_val,
        input logic [31:0]           data,
        input logic [3:0]            be
    );
        sel_write = be[0] ? data[`UAD_SEL_W-1:0] : old_val;
    endfunction : sel_write

    // Write strobe for one register through lane 0, the only lane in use
    function automatic logic lane0_write(
        input logic       take,
        input logic [4:0] addr,
        input logic [3:0] be,
        input logic [4:0] target
    );
        lane0_write = take && be[0] && (addr == target);
    endfunction : lane0_write

    // VBUS sense pin picked per setting
    // R4: VBUS sense select
    uad_pin_pick u_vbus_pick (
        .clk    (clk),
        .nrst   (nrst),
        .gio_in (gio_in),
        .sel    (vbus_pin_select_setting),
        .picked (vbus_seen)
    );

    // Detach input pin picked per setting
    // R6: detach pin select
    uad_pin_pick u_detach_pick (
        .clk    (clk),
        .nrst   (nrst),
        .gio_in (gio_in),
        .sel    (detach_pin_select_setting),
        .picked (detach_seen)
    );

    // External pull-up and wake-up outputs share the general I/O pins
    // R6: wake pin route
    uad_pin_drive u_pin_drive (
        .clk     (clk),
        .nrst    (nrst),
        .a_en    (ext_pullup_on),
        .a_sel   (pullup_pin_select_setting),
        .b_en    (wake_on),
        .b_sel   (wake_pin_select_setting),
        .gio_out (gio_out),
        .gio_oe  (gio_oe)
    );

    // One wait state: waitrequest drops the cycle after a request appears
    // Registering it keeps the address decode out of the bus timing path
    assign rd_take = read && !waitrequest;
    assign wr_take = write && !waitrequest;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            waitrequest <= 1'b1;
        end else if ((read || write) && waitrequest) begin
            waitrequest <= 1'b0;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    // Control register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ready_enum   <= 1'b0;
            self_powered <= 1'b0;
            wake_req     <= 1'b0;
        end else if (lane0_write(wr_take, address, byteenable, `UAD_OFS_CTRL)) begin
            ready_enum   <= writedata[`UAD_CTRL_READY];
            self_powered <= writedata[`UAD_CTRL_SELF_PWR];
            wake_req     <= writedata[`UAD_CTRL_WAKE_REQ];
        end
    end

    // Pin select settings
    // R2: internal is default
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pullup_pin_select_setting <= `UAD_RST_PULLUP_SEL;
            vbus_pin_select_setting   <= `UAD_RST_VBUS_SEL;
            detach_pin_select_setting <= `UAD_RST_DETACH_SEL;
            wake_pin_select_setting   <= `UAD_RST_WAKE_SEL;
        end else if (wr_take) begin
            case (address)
                `UAD_OFS_PULLUP_SEL: pullup_pin_select_setting <=
                    sel_write(pullup_pin_select_setting, writedata, byteenable);
                `UAD_OFS_VBUS_SEL: vbus_pin_select_setting <=
                    sel_write(vbus_pin_select_setting, writedata, byteenable);
                `UAD_OFS_DETACH_SEL: detach_pin_select_setting <=
                    sel_write(detach_pin_select_setting, writedata, byteenable);
                `UAD_OFS_WAKE_SEL: wake_pin_select_setting <=
                    sel_write(wake_pin_select_setting, writedata, byteenable);
                default: ;
            endcase
        end
    end

    // Attach sequencer; detach always wins, VBUS gates only self-powered use
    // Leaving detach goes through OFF so every reconnect runs the full attach
    always_comb begin
        next_state = state;
        case (state)
            uad_pkg::UAD_OFF: begin
                if (detach_seen) begin
                    next_state = uad_pkg::UAD_DETACHED;
                end else if (ready_enum) begin
                    next_state = uad_pkg::UAD_WAIT_VBUS;
                end
            end
            uad_pkg::UAD_WAIT_VBUS: begin
                if (detach_seen) begin
                    next_state = uad_pkg::UAD_DETACHED;
                end else if (!ready_enum) begin
                    next_state = uad_pkg::UAD_OFF;
                end else if (!self_powered || vbus_seen) begin
                    next_state = uad_pkg::UAD_ATTACHED;
                end
            end
            uad_pkg::UAD_ATTACHED: begin
                if (detach_seen) begin
                    next_state = uad_pkg::UAD_DETACHED;
                end else if (!ready_enum || (self_powered && !vbus_seen)) begin
                    next_state = uad_pkg::UAD_OFF;
                end
            end
            uad_pkg::UAD_DETACHED: begin
                if (!detach_seen) begin
                    next_state = uad_pkg::UAD_OFF;
                end
            end
            default: next_state = uad_pkg::UAD_OFF;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= uad_pkg::UAD_OFF;
        end else begin
            state <= next_state;
        end
    end

    // Sequencer state decodes shared by the pull-up, wake and line logic;
    // one place to change if the sequencer grows more states
    assign in_attached = (state == uad_pkg::UAD_ATTACHED);
    assign in_detached = (state == uad_pkg::UAD_DETACHED);

    // Pull-up enable as the AND of its three conditions and the attached state
    // R14: pull-up AND term
    // R1: ready gates pull-up
    // R3: VBUS gates self-powered
    assign pullup_on = ready_enum && !detach_seen && (!self_powered || vbus_seen)
                       && in_attached;
    // R2: pull-up source select
    assign ext_pullup_on = pullup_on && !is_internal(pullup_pin_select_setting);
    // R9: wake only detached
    assign wake_on = wake_req && detach_seen && in_detached;
    // A self-powered board on the internal source is flagged, not blocked
    // R3: self-powered needs external pin
    assign pin_mismatch = self_powered && is_internal(pullup_pin_select_setting);

    // USB-facing outputs, all registered
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dp_internal_pullup <= 1'b0;
            usb_lines_hiz      <= 1'b1;
            usb_remote_wake    <= 1'b0;
        end else begin
            dp_internal_pullup <= pullup_on && is_internal(pullup_pin_select_setting);
            // R7: detach floats lines
            usb_lines_hiz      <= detach_seen || in_detached;
            // R10: no in-cable wake
            usb_remote_wake    <= usb_remote_wake_req && usb_suspend && !detach_seen
                                  && in_attached; // Only from a live, suspended bus
        end
    end

    // Fixed link personality: full-speed peripheral asking for its budget
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            usb_full_speed      <= 1'b0;
            usb_peripheral_role <= 1'b0;
            usb_max_power       <= 8'h00;
        end else begin
            // R12: full speed only
            usb_full_speed      <= 1'b1;
            // R13: peripheral role only
            usb_peripheral_role <= 1'b1;
            // R5: request 200 mA
            usb_max_power       <= self_powered ? 8'h00 : `UAD_BUDGET_UNITS;
        end
    end

    // Suspend on bus power must shed radio and switchable loads
    // R11: suspend current limit
    assign shed_power = usb_suspend && !self_powered;

    // Radio and loads fall together to stay under the suspend limit;
    // a self-powered board is exempt and keeps both running
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            radio_enable    <= 1'b0;
            ext_load_enable <= 1'b0;
        end else begin
            radio_enable    <= !shed_power;
            ext_load_enable <= !shed_power;
        end
    end

    // Sticky flag for a return from detach; a new event beats the clear
    // R8: reattach after detach
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reattached <= 1'b0;
        end else if (in_detached && !detach_seen) begin
            reattached <= 1'b1;
        end else if (lane0_write(wr_take, address, byteenable, `UAD_OFS_STATUS)
                     && writedata[`UAD_ST_REATTACHED]) begin
            reattached <= 1'b0;
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb begin
        next_readdata = 32'h0000_0000;
        case (address)
            `UAD_OFS_CTRL: begin
                next_readdata[`UAD_CTRL_READY]    = ready_enum;
                next_readdata[`UAD_CTRL_SELF_PWR] = self_powered;
                next_readdata[`UAD_CTRL_WAKE_REQ] = wake_req;
            end
            `UAD_OFS_PULLUP_SEL: next_readdata[`UAD_SEL_W-1:0] = pullup_pin_select_setting;
            `UAD_OFS_VBUS_SEL:   next_readdata[`UAD_SEL_W-1:0] = vbus_pin_select_setting;
            `UAD_OFS_DETACH_SEL: next_readdata[`UAD_SEL_W-1:0] = detach_pin_select_setting;
            `UAD_OFS_WAKE_SEL:   next_readdata[`UAD_SEL_W-1:0] = wake_pin_select_setting;
            `UAD_OFS_STATUS: begin
                next_readdata[`UAD_ST_PULLUP]     = pullup_on;
                next_readdata[`UAD_ST_VBUS]       = vbus_seen;
                next_readdata[`UAD_ST_DETACH]     = detach_seen;
                next_readdata[`UAD_ST_SUSPEND]    = usb_suspend;
                next_readdata[`UAD_ST_WAKE]       = wake_on;
                next_readdata[`UAD_ST_MISMATCH]   = pin_mismatch;
                next_readdata[`UAD_ST_REATTACHED] = reattached;
            end
            `UAD_OFS_POWER: next_readdata[15:0] = self_powered ? 16'h0000 : `UAD_BUDGET_MA;
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    // Read data is captured as waitrequest falls and held for the taking edge
    // The captured word reflects the state one cycle before the take edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            readdata <= 32'h0000_0000;
        end else if (read && waitrequest) begin
            readdata <= next_readdata;
        end
    end

endmodule : uad_attach_ctrl
`default_nettype wire

/* uad_attach_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module uad_attach_ctrl_properties (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [4:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic        waitrequest,
    input wire logic [15:0] gio_in,
    input wire logic [15:0] gio_oe,
    input wire logic        usb_suspend,
    input wire logic        dp_internal_pullup,
    input wire logic        usb_lines_hiz,
    input wire logic        usb_remote_wake,
    input wire logic        usb_full_speed,
    input wire logic        usb_peripheral_role,
    input wire logic [7:0]  usb_max_power,
    input wire logic        radio_enable,
    input wire logic        ext_load_enable
);
    logic [4:0] sel [1:4];
    logic [2:0] ctl;
    logic       det;
    logic       vb;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Shadow of the settings, taken where the slave accepts a write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl    <= 3'h0;
            sel[1] <= 5'h10;
            sel[2] <= 5'h02;
            sel[3] <= 5'h03;
            sel[4] <= 5'h04;
        end else if (write && !waitrequest && byteenable[0] && address < 5'h14
                     && address[1:0] == 2'h0) begin
            if (address == 5'h00) begin
                ctl <= writedata[2:0];
            end else begin
                sel[address[4:2]] <= writedata[4:0];
            end
        end
    end

    // Sensed pins; a select of 16 or more reads low
    assign det = !sel[3][4] && gio_in[sel[3][3:0]];
    assign vb  = !sel[2][4] && gio_in[sel[2][3:0]];

    // Repetition counts leave room for the three-stage pin pipeline
    AST_DETACH_FLOATS: assert property (det [*5] |-> usb_lines_hiz && !dp_internal_pullup)
        else $error("lines not floated while detached");
    AST_REATTACH: assert property ((!det) [*5] |-> !usb_lines_hiz)
        else $error("lines still floated after detach low");
    AST_PULLUP_ON: assert property ((ctl[0] && !det && (!ctl[1] || vb) && sel[1] == 5'h10) [*8]
        |-> dp_internal_pullup) else $error("internal pull-up missing");
    AST_NOT_READY: assert property ((!ctl[0]) [*5] |-> !dp_internal_pullup)
        else $error("pull-up before ready");
    AST_NO_VBUS: assert property ((ctl[1] && !vb) [*5] |-> !dp_internal_pullup
        && !(sel[1] < 5'h10 && gio_oe[sel[1][3:0]])) else $error("pull-up without vbus");
    AST_EXT_SOURCE: assert property ((sel[1] < 5'h10) [*5] |-> !dp_internal_pullup)
        else $error("internal pull-up with external select");
    AST_BUDGET: assert property (($stable(ctl[1])) [*4]
        |-> usb_max_power == (ctl[1] ? 8'h00 : 8'h64)) else $error("supply budget wrong");
    AST_WAKE_PIN: assert property ((!det && sel[4] < 5'h10 && sel[4] != sel[1]) [*5]
        |-> !gio_oe[sel[4][3:0]]) else $error("wake pin driven while attached");
    AST_NO_CABLE_WAKE: assert property (det [*5] |-> !usb_remote_wake)
        else $error("in-cable wake while detached");
    AST_SUSPEND: assert property ((usb_suspend && !ctl[1]) [*4]
        |-> !radio_enable && !ext_load_enable) else $error("loads on in suspend");
    AST_ROLE: assert property ($past(nrst) |-> usb_full_speed && usb_peripheral_role)
        else $error("speed or role wrong");
    AST_ONE_WAIT: assert property ((read || write) |-> ##[0:2] !waitrequest)
        else $error("bus access not answered");

    // Main scenarios reached
    COV_DETACH: cover property (det [*5] ##1 !det);
    COV_PULLUP: cover property ($rose(dp_internal_pullup));
    COV_SUSPEND: cover property ($fell(radio_enable));
endmodule : uad_attach_ctrl_properties

bind uad_attach_ctrl uad_attach_ctrl_properties uad_attach_ctrl_properties_i (.*);

`default_nettype wire

/* uad_attach_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uad_defs.svh"

module uad_attach_ctrl_tb;
    logic        clk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0, waitrequest;
    logic [4:0]  address = 5'h00;
    logic [31:0] writedata = 32'h0, readdata, q;
    logic [3:0]  byteenable = 4'hF, vb_pin = 4'h2, dt_pin = 4'h3;
    logic [15:0] gio_in, gio_out, gio_oe;
    logic        vb_on = 1'b1, dt_on = 1'b0, su_cmd = 1'b0, wk_cmd = 1'b0;
    logic        usb_suspend, usb_remote_wake_req, dp_internal_pullup, usb_lines_hiz;
    logic        usb_remote_wake, usb_full_speed, usb_peripheral_role, radio_enable;
    logic        ext_load_enable, r, s, v, d;
    logic [7:0]  usb_max_power;
    int          err_count = 0, n_tests = 0, p;
    logic [4:0]  ra [7] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h18, 5'h1C};
    logic [31:0] rv [7] = '{32'h0, 32'h10, 32'h2, 32'h3, 32'h4, 32'hC8, 32'h0};

    always #25 clk = ~clk;

    uad_attach_ctrl uad_attach_ctrl_i (.clk(clk), .nrst(nrst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .gio_in(gio_in), .gio_out(gio_out), .gio_oe(gio_oe),
        .usb_suspend(usb_suspend), .usb_remote_wake_req(usb_remote_wake_req),
        .dp_internal_pullup(dp_internal_pullup), .usb_lines_hiz(usb_lines_hiz),
        .usb_remote_wake(usb_remote_wake), .usb_full_speed(usb_full_speed),
        .usb_peripheral_role(usb_peripheral_role), .usb_max_power(usb_max_power),
        .radio_enable(radio_enable), .ext_load_enable(ext_load_enable));

    uad_host_model uad_host_model_i (.gio_out(gio_out), .gio_oe(gio_oe), .vb_on(vb_on),
        .dt_on(dt_on), .su_cmd(su_cmd), .wk_cmd(wk_cmd), .vb_pin(vb_pin), .dt_pin(dt_pin),
        .gio_in(gio_in), .usb_suspend(usb_suspend),
        .usb_remote_wake_req(usb_remote_wake_req));

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // One bus access; the request holds until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] dt);
        int n;
        n = 0;
        @(posedge clk);
        address   <= a;
        write     <= w;
        read      <= !w;
        writedata <= dt;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0);
        chk(32'(n), 32'h2);
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt

    // Pull-up expected from ready, self power, vbus and detach
    function automatic logic exp_pu(input logic rd, sp, vp, dp);
        return rd && (!sp || vp) && !dp;
    endfunction : exp_pu

    task automatic close_out;
        if (err_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out

    // Watchdog well beyond the roughly 300 cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        close_out();
    end

    initial begin
        void'($urandom(32'hE31ADD80));
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        wt(2);
        chk(usb_full_speed && usb_peripheral_role, 1);
        foreach (ra[i]) begin
            bus(1'b0, ra[i], 32'h0);
            chk(q, rv[i]);
        end
        // Unmapped and lane-off writes are dropped
        bus(1'b1, 5'h1C, 32'hFFFFFFFF);
        byteenable <= 4'h0;
        bus(1'b1, `UAD_OFS_CTRL, 32'h7);
        byteenable <= 4'hF;
        bus(1'b0, `UAD_OFS_CTRL, 32'h0);
        chk(q, 0);
        bus(1'b1, `UAD_OFS_CTRL, 32'h1);
        wt(8);
        chk({dp_internal_pullup, usb_max_power}, 9'h164);
        // Detach with a pending wake request, then return
        wk_cmd <= 1'b1;
        bus(1'b1, `UAD_OFS_CTRL, 32'h5);
        dt_on <= 1'b1;
        wt(8);
        chk({usb_lines_hiz, dp_internal_pullup, usb_remote_wake}, 3'b100);
        chk({gio_oe[4], gio_out[4]}, 2'b11);
        dt_on <= 1'b0;
        wt(8);
        chk({usb_lines_hiz, dp_internal_pullup, usb_remote_wake, gio_oe[4]}, 4'b0100);
        bus(1'b0, `UAD_OFS_STATUS, 32'h0);
        chk(q, 32'h43);
        bus(1'b1, `UAD_OFS_STATUS, 32'h40);
        bus(1'b0, `UAD_OFS_STATUS, 32'h0);
        chk(q, 32'h3);
        // Suspend matters only when bus powered
        su_cmd <= 1'b1;
        wt(8);
        chk({radio_enable, ext_load_enable}, 2'b00);
        chk(usb_remote_wake, 1);
        bus(1'b1, `UAD_OFS_CTRL, 32'h3);
        wt(8);
        chk({radio_enable, ext_load_enable, usb_max_power}, 10'h300);
        su_cmd <= 1'b0;
        vb_on  <= 1'b0;
        wt(8);
        chk(dp_internal_pullup, 0);
        // Move vbus, pull-up and detach onto other pins
        p = 8 + $urandom_range(7);
        bus(1'b1, `UAD_OFS_VBUS_SEL, 32'(5 + $urandom_range(2)));
        vb_pin <= writedata[3:0];
        bus(1'b1, `UAD_OFS_PULLUP_SEL, 32'(p));
        bus(1'b1, `UAD_OFS_DETACH_SEL, 32'h1);
        dt_pin <= 4'h1;
        repeat (16) begin
            {r, s, v, d} = 4'($urandom);
            bus(1'b1, `UAD_OFS_CTRL, {30'h0, s, r});
            vb_on <= v;
            dt_on <= d;
            wt(8);
            chk({gio_oe[p], dp_internal_pullup}, {exp_pu(r, s, v, d), 1'b0});
            chk(usb_lines_hiz, d);
        end
        close_out();
    end
endmodule : uad_attach_ctrl_tb

`default_nettype wire

/* uad_defs.svh */
`ifndef UAD_DEFS_SVH
`define UAD_DEFS_SVH

// Register byte offsets on the Avalon-MM slave
`define UAD_OFS_CTRL        5'h00
`define UAD_OFS_PULLUP_SEL  5'h04
`define UAD_OFS_VBUS_SEL    5'h08
`define UAD_OFS_DETACH_SEL  5'h0C
`define UAD_OFS_WAKE_SEL    5'h10
`define UAD_OFS_STATUS      5'h14
`define UAD_OFS_POWER       5'h18

// Control register fields
`define UAD_CTRL_READY      0
`define UAD_CTRL_SELF_PWR   1
`define UAD_CTRL_WAKE_REQ   2

// Status register fields
`define UAD_ST_PULLUP       0
`define UAD_ST_VBUS         1
`define UAD_ST_DETACH       2
`define UAD_ST_SUSPEND      3
`define UAD_ST_WAKE         4
`define UAD_ST_MISMATCH     5
`define UAD_ST_REATTACHED   6

// Pin select settings and reset values
`define UAD_SEL_W           5
`define UAD_GIO_W           16
`define UAD_SEL_INTERNAL    5'h10
`define UAD_RST_PULLUP_SEL  5'h10
`define UAD_RST_VBUS_SEL    5'h02
`define UAD_RST_DETACH_SEL  5'h03
`define UAD_RST_WAKE_SEL    5'h04

// Supply budget asked for during enumeration, in mA and in 2 mA units
`define UAD_BUDGET_MA       16'h00C8
`define UAD_BUDGET_UNITS    8'h64

`endif

/* uad_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module uad_host_model (
    input  wire logic [15:0] gio_out,
    input  wire logic [15:0] gio_oe,
    input  wire logic        vb_on,
    input  wire logic        dt_on,
    input  wire logic        su_cmd,
    input  wire logic        wk_cmd,
    input  wire logic [3:0]  vb_pin,
    input  wire logic [3:0]  dt_pin,
    output logic      [15:0] gio_in,
    output logic             usb_suspend,
    output logic             usb_remote_wake_req
);
    assign usb_suspend         = su_cmd;
    assign usb_remote_wake_req = wk_cmd;

    // Board pins: driven value wins, else sensed level, else pull-down
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            gio_in[i] = gio_oe[i] ? gio_out[i] : (i == vb_pin) ? vb_on : (i == dt_pin) && dt_on;
        end
    end
endmodule : uad_host_model

`default_nettype wire

/* uad_pin_drive.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uad_defs.svh"

module uad_pin_drive (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic                   a_en,
    input  wire logic [`UAD_SEL_W-1:0]  a_sel,
    input  wire logic                   b_en,
    input  wire logic [`UAD_SEL_W-1:0]  b_sel,
    output logic      [`UAD_GIO_W-1:0]  gio_out,
    output logic      [`UAD_GIO_W-1:0]  gio_oe
);

    logic [`UAD_GIO_W-1:0] next_out;
    logic [`UAD_GIO_W-1:0] next_oe;

    // Each channel drives its selected pin high while enabled, else floats it
    always_comb begin
        next_out = '0;
        next_oe  = '0;
        if (a_en && a_sel < `UAD_SEL_INTERNAL) begin
            next_out[a_sel[3:0]] = 1'b1;
            next_oe[a_sel[3:0]]  = 1'b1;
        end
        if (b_en && b_sel < `UAD_SEL_INTERNAL) begin
            next_out[b_sel[3:0]] = 1'b1;
            next_oe[b_sel[3:0]]  = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gio_out <= '0;
            gio_oe  <= '0;
        end else begin
            gio_out <= next_out;
            gio_oe  <= next_oe;
        end
    end

endmodule : uad_pin_drive
`default_nettype wire

/* uad_pin_pick.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uad_defs.svh"

module uad_pin_pick (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic [`UAD_GIO_W-1:0]  gio_in,
    input  wire logic [`UAD_SEL_W-1:0]  sel,
    output logic                        picked
);

    // Registered pick; an index past the last pin reads as low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            picked <= 1'b0;
        end else if (sel < `UAD_SEL_INTERNAL) begin
            picked <= gio_in[sel[3:0]];
        end else begin
            picked <= 1'b0;
        end
    end

endmodule : uad_pin_pick
`default_nettype wire

/* uad_pkg.sv */
package uad_pkg;

    // Attach sequencer states
    typedef enum logic [1:0] {
        UAD_OFF,
        UAD_WAIT_VBUS,
        UAD_ATTACHED,
        UAD_DETACHED
    } uad_state_type;

endpackage : uad_pkg
